// file: inc/cido_pkg.sv
// shared constants and types for the clear/invert/decrement executor
package cido_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus and data widths
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 32;
    localparam int OP_W       = 14;
    localparam int FILE_ADR_W = 7;
    localparam int FILE_DEPTH = 128;

    ////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [11:0] REG_INSTR  = 12'h000;
    localparam logic [11:0] REG_ACC    = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [2:0]  FILE_SEL   = 3'h2;

    ////////////////////////////////////////////////////////////////////////
    // opcode fields and encodings
    localparam int          OP_HI_MSB  = 13;
    localparam int          OP_HI_LSB  = 8;
    localparam int          DEST_BIT   = 7;
    localparam logic [5:0]  GRP_DEC    = 6'h03;
    localparam logic [5:0]  GRP_INV    = 6'h09;
    localparam logic [13:0] OP_CLR_ACC = 14'h0103;
    localparam logic [13:0] OP_KICK    = 14'h0064;

    ////////////////////////////////////////////////////////////////////////
    // status field positions
    localparam int ST_ZERO   = 0;
    localparam int ST_EXPIRY = 1;
    localparam int ST_SLEEP  = 2;
    localparam int ST_BADOP  = 3;
    localparam int ST_W      = 4;

    ////////////////////////////////////////////////////////////////////////
    // bus carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cido_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } cido_apb_rsp_t;

    ////////////////////////////////////////////////////////////////////////
    // whole block state
    typedef struct packed {
        logic [127:0][7:0] file;
        logic [13:0]       instr;
        logic [7:0]        acc;
        logic [3:0]        status;
        logic              wdt_clear;
        logic              pre_clear;
        cido_apb_rsp_t     rsp;
    } cido_state_t;

    // expiry and sleep flags stand at one after power-up
    localparam logic [3:0] STATUS_RST = 4'h6;

endpackage

// file: verilog/cido_core.sv
// executor for clear-acc, invert, decrement and watchdog-kick opcodes
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

//Contract
//RULE_01 - clear-accumulator opcode loads zero into accumulator and sets zero flag
//RULE_02 - watchdog-kick opcode resets the watchdog counter to zero
//RULE_03 - watchdog-kick opcode also clears the watchdog prescaler count
//RULE_04 - watchdog-kick opcode sets expiry and sleep-entered flags to one
//RULE_05 - decrement subtracts one from file register; zero flag follows result
//RULE_06 - destination bit zero writes accumulator, one writes file register
//RULE_07 - operand opcodes carry 7-bit file address and one destination bit
//RULE_08 - invert writes complement to destination and updates zero flag
module cido_core #(
    // file register count, bound to the 7-bit operand address
    parameter int unsigned FILE_DEPTH_P = cido_pkg::FILE_DEPTH
) (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // register bus
    input  wire cido_pkg::cido_apb_req_t apb_req,
    output var  cido_pkg::cido_apb_rsp_t apb_rsp,
    // watchdog side
    output var  logic                   wdt_clear,
    output var  logic                   prescaler_clear,
    // observed core state
    output var  logic [7:0]             accumulator,
    output var  logic                   zero_flag,
    output var  logic                   watchdog_expiry_flag,
    output var  logic                   sleep_entered_flag
);
    import cido_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (FILE_DEPTH_P != FILE_DEPTH) begin
        $error("file depth must cover the 7-bit operand address");
    end
    if (OP_HI_LSB != DEST_BIT + 1 || DEST_BIT != FILE_ADR_W) begin
        $error("opcode fields overlap");
    end
    if (OP_HI_MSB != OP_W - 1) begin
        $error("opcode group field must end at the top bit");
    end
    if (ST_W != $bits(STATUS_RST)) begin
        $error("status width differs from its reset value");
    end

    ////////////////////////////////////////////////////////////////////////
    // one-hot decodes
    // opcode class of the written word
    typedef enum logic [4:0] {
        CIDO_CLS_BAD  = 5'b00001,
        CIDO_CLS_CLR  = 5'b00010,
        CIDO_CLS_KICK = 5'b00100,
        CIDO_CLS_DEC  = 5'b01000,
        CIDO_CLS_INV  = 5'b10000
    } cido_op_cls_t;

    // register selected by the current bus address
    typedef enum logic [4:0] {
        CIDO_SEL_NONE   = 5'b00001,
        CIDO_SEL_FILE   = 5'b00010,
        CIDO_SEL_INSTR  = 5'b00100,
        CIDO_SEL_ACC    = 5'b01000,
        CIDO_SEL_STATUS = 5'b10000
    } cido_reg_sel_t;

    ////////////////////////////////////////////////////////////////////////
    // state
    cido_state_t s_q;
    cido_state_t s_d;

    // bus side
    logic                  access;
    logic                  commit;
    logic                  wr_ok;
    logic                  wr_file;
    cido_reg_sel_t         reg_sel;
    logic [FILE_ADR_W-1:0] bus_idx;
    logic [31:0]           rd_word;

    // opcode side
    logic [13:0]           op;
    logic [FILE_ADR_W-1:0] op_f;
    logic                  op_dest;
    cido_op_cls_t          op_cls;
    logic [7:0]            operand;
    logic [7:0]            result;
    logic                  has_result;
    logic                  exec;
    logic                  res_to_file;
    logic                  res_to_acc;

    // next values, file registers one per entry
    logic [7:0]            acc_nxt;
    logic [ST_W-1:0]       status_nxt;
    logic [7:0]            file_nxt [FILE_DEPTH_P];

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    assign access  = apb_req.psel & apb_req.penable;
    assign commit  = access & s_q.rsp.pready;
    assign bus_idx = apb_req.paddr[8:2];

    always_comb begin
        reg_sel = CIDO_SEL_NONE;
        if (apb_req.paddr[1:0] != 2'h0) begin
            reg_sel = CIDO_SEL_NONE;
        end else if (apb_req.paddr[11:9] == FILE_SEL) begin
            reg_sel = CIDO_SEL_FILE;
        end else if (apb_req.paddr == REG_INSTR) begin
            reg_sel = CIDO_SEL_INSTR;
        end else if (apb_req.paddr == REG_ACC) begin
            reg_sel = CIDO_SEL_ACC;
        end else if (apb_req.paddr == REG_STATUS) begin
            reg_sel = CIDO_SEL_STATUS;
        end
    end

    // writes land on the edge that sees pready; refused ones never do
    assign wr_ok   = commit & apb_req.pwrite & !s_q.rsp.pslverr;
    assign wr_file = wr_ok & (reg_sel == CIDO_SEL_FILE);

    // read data prepared in the first access cycle, unused bits zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (reg_sel)
            CIDO_SEL_FILE: begin
                rd_word = {24'h00_0000, s_q.file[bus_idx]};
            end
            CIDO_SEL_INSTR: begin
                rd_word = {18'h0_0000, s_q.instr};
            end
            CIDO_SEL_ACC: begin
                rd_word = {24'h00_0000, s_q.acc};
            end
            CIDO_SEL_STATUS: begin
                rd_word = {28'h000_0000, s_q.status};
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // opcode fields of the word being written
    assign op      = apb_req.pwdata[OP_W-1:0];
    assign op_f    = op[FILE_ADR_W-1:0];                          // RULE_07
    assign op_dest = op[DEST_BIT];                                // RULE_07
    assign operand = s_q.file[op_f];
    assign exec    = wr_ok & (reg_sel == CIDO_SEL_INSTR);

    always_comb begin
        op_cls = CIDO_CLS_BAD;
        if (op == OP_CLR_ACC) begin
            op_cls = CIDO_CLS_CLR;
        end else if (op == OP_KICK) begin
            op_cls = CIDO_CLS_KICK;
        end else if (op[OP_HI_MSB:OP_HI_LSB] == GRP_DEC) begin
            op_cls = CIDO_CLS_DEC;
        end else if (op[OP_HI_MSB:OP_HI_LSB] == GRP_INV) begin
            op_cls = CIDO_CLS_INV;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operand arithmetic
    always_comb begin
        result     = 8'h00;
        has_result = 1'b0;
        case (op_cls)
            CIDO_CLS_DEC: begin
                result     = operand - 8'h01;                     // RULE_05
                has_result = 1'b1;
            end
            CIDO_CLS_INV: begin
                result     = ~operand;                            // RULE_08
                has_result = 1'b1;
            end
            default: begin
                result     = 8'h00;
                has_result = 1'b0;
            end
        endcase
    end

    // destination bit steers an operand result
    assign res_to_file = exec & has_result & op_dest;             // RULE_06
    assign res_to_acc  = exec & has_result & !op_dest;            // RULE_06

    ////////////////////////////////////////////////////////////////////////
    // file registers, one next-value mux per entry
    // a bus write and an opcode result never share a transfer
    for (genvar i = 0; i < FILE_DEPTH_P; i++) begin : g_file
        localparam logic [FILE_ADR_W-1:0] IDX = FILE_ADR_W'(i);
        logic sel_bus;
        logic sel_op;
        assign sel_bus = wr_file & (bus_idx == IDX);
        assign sel_op  = res_to_file & (op_f == IDX);             // RULE_06
        assign file_nxt[i] = sel_bus ? apb_req.pwdata[7:0] :
                             sel_op  ? result : s_q.file[i];
    end

    ////////////////////////////////////////////////////////////////////////
    // accumulator next value
    always_comb begin
        acc_nxt = s_q.acc;
        if (wr_ok && reg_sel == CIDO_SEL_ACC) begin
            acc_nxt = apb_req.pwdata[7:0];
        end else if (exec && op_cls == CIDO_CLS_CLR) begin
            acc_nxt = 8'h00;                                      // RULE_01
        end else if (res_to_acc) begin
            acc_nxt = result;                                     // RULE_06
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status next value
    // software write overwrites all bits; no opcode lands with it
    always_comb begin
        status_nxt = s_q.status;
        if (wr_ok && reg_sel == CIDO_SEL_STATUS) begin
            status_nxt = apb_req.pwdata[ST_W-1:0];
        end else if (exec) begin
            case (op_cls)
                CIDO_CLS_CLR: begin
                    status_nxt[ST_ZERO] = 1'b1;                   // RULE_01
                end
                CIDO_CLS_KICK: begin
                    status_nxt[ST_EXPIRY] = 1'b1;                 // RULE_04
                    status_nxt[ST_SLEEP]  = 1'b1;                 // RULE_04
                end
                CIDO_CLS_DEC, CIDO_CLS_INV: begin
                    status_nxt[ST_ZERO] = (result == 8'h00); // RULE_05 RULE_08
                end
                default: begin
                    // unknown opcode: only the opcode word and the bad-opcode flag change
                    status_nxt[ST_BADOP] = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d             = s_q;
        s_d.wdt_clear   = 1'b0;
        s_d.pre_clear   = 1'b0;
        s_d.rsp.pready  = 1'b0;
        s_d.rsp.pslverr = 1'b0;
        s_d.rsp.prdata  = 32'h0000_0000;
        s_d.acc         = acc_nxt;
        s_d.status      = status_nxt;

        // first access cycle: decode, prepare answer for the next cycle
        if (access && !s_q.rsp.pready) begin
            s_d.rsp.pready  = 1'b1;
            s_d.rsp.pslverr = (reg_sel == CIDO_SEL_NONE);
            s_d.rsp.prdata  = rd_word;
        end

        // opcode word kept for read-back, unknown ones too
        if (exec) begin
            s_d.instr = op;
            if (op_cls == CIDO_CLS_KICK) begin
                s_d.wdt_clear = 1'b1;                             // RULE_02
                s_d.pre_clear = 1'b1;                             // RULE_03
            end
        end

        // file registers from their per-entry muxes
        for (int k = 0; k < FILE_DEPTH_P; k++) begin
            s_d.file[k] = file_nxt[k];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.status <= STATUS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign apb_rsp              = s_q.rsp;
    assign wdt_clear            = s_q.wdt_clear;
    assign prescaler_clear      = s_q.pre_clear;
    assign accumulator          = s_q.acc;
    assign zero_flag            = s_q.status[ST_ZERO];
    assign watchdog_expiry_flag = s_q.status[ST_EXPIRY];
    assign sleep_entered_flag   = s_q.status[ST_SLEEP];

endmodule
`default_nettype wire

// file: verif/cido_assertions.sv
// property checker for the opcode executor ports
`timescale 1ns/1ps
`default_nettype none
module cido_chk (
    // clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // register bus
    input wire cido_pkg::cido_apb_req_t apb_req,
    input wire cido_pkg::cido_apb_rsp_t apb_rsp,
    // core outputs
    input wire logic                    wdt_clear,
    input wire logic                    prescaler_clear,
    input wire logic [7:0]              accumulator,
    input wire logic                    zero_flag,
    input wire logic                    watchdog_expiry_flag,
    input wire logic                    sleep_entered_flag
);
    import cido_pkg::*;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic        done;
    logic        wr_op;
    logic [13:0] op;
    assign done  = apb_req.psel & apb_req.penable & apb_rsp.pready;
    assign op    = apb_req.pwdata[13:0];
    assign wr_op = done & apb_req.pwrite & (apb_req.paddr == REG_INSTR);
    clr_acc_a: assert property (wr_op && op == OP_CLR_ACC
        |=> accumulator == 8'h00 && zero_flag) else $error("clear wrong");
    kick_pulse_a: assert property (wr_op && op == OP_KICK
        |=> wdt_clear ##1 !wdt_clear) else $error("kick pulse wrong");
    pre_pair_a: assert property (wdt_clear == prescaler_clear)
        else $error("prescaler clear apart from counter clear");
    kick_flags_a: assert property ($rose(wdt_clear)
        |-> watchdog_expiry_flag && sleep_entered_flag) else $error("flags");
    dec_zero_a: assert property (wr_op && op[13:8] == GRP_DEC
        && !op[DEST_BIT] |=> zero_flag == (accumulator == 8'h00))
        else $error("decrement zero wrong");
    inv_zero_a: assert property (wr_op && op[13:8] == GRP_INV
        && !op[DEST_BIT] |=> zero_flag == (accumulator == 8'h00))
        else $error("invert zero wrong");
    acc_hold_a: assert property (wr_op && op[DEST_BIT]
        |=> $stable(accumulator)) else $error("accumulator touched");
    acc_cause_a: assert property ($changed(accumulator)
        |-> $past(done)) else $error("accumulator moved idle");
    cover property (wr_op && op == OP_KICK);
    cover property (wr_op && op[13:8] == GRP_INV);
    cover property (done && apb_rsp.pslverr);
endmodule
`default_nettype wire

// file: verif/clear_invert_decrement_ops_tb_top.sv
// self-checking bench for the opcode executor
`timescale 1ns/1ps
`default_nettype none
module clear_invert_decrement_ops_tb_top;
    import cido_pkg::*;
    typedef struct packed {
        logic [13:0] op;
        logic [11:0] ra;
        logic [7:0]  ev;
        logic        z;
    } cido_row_t;
    logic          pclk    = 1'b0;
    logic          presetn = 1'b0;
    cido_apb_req_t req     = '0;
    cido_apb_rsp_t rsp;
    logic          wclr, pclr, zf, ef, sf, err;
    logic [7:0]    acc;
    logic [31:0]   rd;
    int            mismatches  = 0;
    int            check_count = 0;
    int            kicks       = 0;
    cido_row_t     rows [6] = '{
        '{14'h0380, 12'h400, 8'h00, 1'b1},
        '{14'h0905, REG_ACC, 8'hEC, 1'b0},
        '{14'h037F, REG_ACC, 8'hFF, 1'b0},
        '{14'h09FF, 12'h5FC, 8'hFF, 1'b0},
        '{14'h0103, REG_ACC, 8'h00, 1'b1},
        '{14'h03FF, 12'h5FC, 8'hFE, 1'b0}};
    always #20 pclk = ~pclk;
    always @(negedge pclk) if (wclr && pclr) kicks++;
    cido_core uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .wdt_clear(wclr), .prescaler_clear(pclr),
        .accumulator(acc), .zero_flag(zf), .watchdog_expiry_flag(ef),
        .sleep_entered_flag(sf));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge pclk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, 12'h400, 32'h01);
        apb(1'b1, 12'h414, 32'h13);
        apb(1'b1, 12'h5FC, 32'h00);
        foreach (rows[i]) begin
            apb(1'b1, REG_INSTR, {18'h0, rows[i].op});
            cmp(zf, rows[i].z);
            apb(1'b0, rows[i].ra, 32'h0);
            cmp(rd, rows[i].ev);
        end
        apb(1'b0, 12'h414, 32'h0);
        cmp(rd, 32'h13);
        apb(1'b1, REG_STATUS, 32'h0);
        cmp({ef, sf}, 2'b00);
        apb(1'b1, REG_INSTR, {18'h0, OP_KICK});
        cmp({ef, sf, kicks[1:0]}, 4'hD);
        apb(1'b0, 12'h00C, 32'h0);
        cmp(err, 1'b1);
        apb(1'b1, REG_INSTR, 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        cmp(rd[3], 1'b1);
        presetn <= 1'b0;
        @(posedge pclk);
        cmp({ef, sf, zf, acc}, 11'h600);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h5FC, 32'h0);
        cmp(rd, 32'h0);
        complete_run();
    end
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
endmodule
bind cido_core cido_chk chk (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .wdt_clear(wdt_clear),
    .prescaler_clear(prescaler_clear), .accumulator(accumulator),
    .zero_flag(zero_flag), .watchdog_expiry_flag(watchdog_expiry_flag),
    .sleep_entered_flag(sleep_entered_flag));
`default_nettype wire
